// File: src/dnrw_cell_array.sv
// byte-wide data memory cells with a timed write engine
// assumes the controller starts a write only while the engine is idle
module dnrw_cell_array #(
	parameter int unsigned WRITE_CYCLES = dnrw_pkg::WRITE_CYCLES
) (
	// clock and reset
	input  wire logic   hclk,
	input  wire logic   hresetn,
	// controller side
	dnrw_mem_if.mem     mem_port
);

	logic [7:0]                 cells_q [dnrw_pkg::DEPTH]; // nonvolatile cells, never reset
	dnrw_pkg::dnrw_wr_state_t   state_q;                   // engine state
	logic [dnrw_pkg::CNT_W-1:0] cnt_q;                     // cycles spent in this write
	logic [7:0]                 addr_q;                    // captured target index
	logic [7:0]                 data_q;                    // captured byte
	logic                       done_q;                    // completion pulse
	wire logic                  last_cycle;                // write time used up
	wire logic                  land;                      // byte goes into the cells

	// reads are immediate so the fetched byte is ready next edge
	assign mem_port.rd_data = cells_q[mem_port.rd_addr];
	assign mem_port.wr_busy = (state_q == dnrw_pkg::DNRW_WR_BUSY);
	assign mem_port.wr_done = done_q;
	assign last_cycle = (cnt_q == dnrw_pkg::CNT_W'(WRITE_CYCLES - 1));
	assign land       = mem_port.wr_busy & last_cycle & ~mem_port.wr_abort;

	// engine: capture on start, count the write time, abort drops the byte
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= dnrw_pkg::DNRW_WR_IDLE;
			cnt_q   <= dnrw_pkg::CNT_RESET;
			addr_q  <= dnrw_pkg::INDEX_RESET;
			data_q  <= dnrw_pkg::VALUE_RESET;
			done_q  <= 1'b0;
		end else begin
			done_q <= land;
			case (state_q)
				dnrw_pkg::DNRW_WR_IDLE: begin
					cnt_q <= dnrw_pkg::CNT_RESET;
					if (mem_port.wr_start) begin
						addr_q  <= mem_port.wr_addr; // later register writes cannot alter it
						data_q  <= mem_port.wr_data;
						state_q <= dnrw_pkg::DNRW_WR_BUSY;
					end
				end
				dnrw_pkg::DNRW_WR_BUSY: begin
					if (mem_port.wr_abort || last_cycle) begin
						state_q <= dnrw_pkg::DNRW_WR_IDLE; // finish or give up
					end else begin
						cnt_q <= cnt_q + 1'b1; // implementation-defined write length
					end
				end
				default: begin
					state_q <= dnrw_pkg::DNRW_WR_IDLE;
				end
			endcase
		end
	end

	// cell update, no reset so contents persist
	always_ff @(posedge hclk) begin
		if (land) begin
			cells_q[addr_q] <= data_q;
		end
	end

endmodule : dnrw_cell_array

// File: src/dnrw_mem_if.sv
// link between the access controller and the cell array
// assumes both ends run on the same core clock
interface dnrw_mem_if;
	logic [7:0] rd_addr;  // read index, combinational read
	logic [7:0] rd_data;  // addressed byte
	logic       wr_start; // one-cycle start of a write cycle
	logic [7:0] wr_addr;  // index captured at start
	logic [7:0] wr_data;  // byte captured at start
	logic       wr_abort; // cut the running write short
	logic       wr_busy;  // write cycle in progress
	logic       wr_done;  // one-cycle pulse, write landed

	modport ctrl (
		output rd_addr, wr_start, wr_addr, wr_data, wr_abort,
		input  rd_data, wr_busy, wr_done
	);
	modport mem (
		input  rd_addr, wr_start, wr_addr, wr_data, wr_abort,
		output rd_data, wr_busy, wr_done
	);
endinterface : dnrw_mem_if

// File: src/dnrw_pkg.sv
// constants shared by the data memory access controller and its cell array
// assumes a 25 MHz core clock and word-aligned AHB-Lite register accesses
package dnrw_pkg;

	// register byte offsets, compared against the low address bits
	localparam int unsigned  ADDR_W         = 8;
	localparam logic [7:0]   OFF_CONTROL    = 8'h00; // nvm_control
	localparam logic [7:0]   OFF_UNLOCK     = 8'h04; // unlock_port, not a physical register
	localparam logic [7:0]   OFF_INDEX      = 8'h08; // nvm_index
	localparam logic [7:0]   OFF_VALUE      = 8'h0C; // nvm_value
	localparam logic [7:0]   OFF_IRQ_STATUS = 8'h10; // sticky events, write one to clear
	localparam logic [7:0]   OFF_IRQ_MASK   = 8'h14; // same layout as status

	// nvm_control field positions
	localparam int unsigned  CTL_FETCH_BIT  = 0; // fetch_trigger
	localparam int unsigned  CTL_COMMIT_BIT = 1; // commit_trigger
	localparam int unsigned  CTL_ENABLE_BIT = 2; // commit_unlock_enable
	localparam int unsigned  CTL_ABORT_BIT  = 3; // commit_abort_flag
	localparam int unsigned  CTL_SPACE_BIT  = 7; // space_select, 1 = program memory

	// interrupt status and mask field positions
	localparam int unsigned  IRQ_DONE_BIT   = 0; // commit_done_flag
	localparam int unsigned  IRQ_ABORT_BIT  = 1; // write cut short
	localparam int unsigned  IRQ_W          = 2;

	// values after reset
	localparam logic [7:0]        INDEX_RESET = 8'h00;
	localparam logic [7:0]        VALUE_RESET = 8'h00;
	localparam logic [IRQ_W-1:0]  IRQ_RESET   = 2'h0;

	// unlock keys
	localparam logic [7:0]   UNLOCK_KEY1    = 8'h55;
	localparam logic [7:0]   UNLOCK_KEY2    = 8'hAA;

	// memory geometry
	localparam int unsigned  DATA_W         = 8;
	localparam int unsigned  DEPTH          = 256;

	// write cycle timing
	localparam int unsigned  CLK_FREQ_MHZ   = 25;
	localparam int unsigned  WRITE_TIME_US  = 4000;
	localparam int unsigned  WRITE_CYCLES   = WRITE_TIME_US * CLK_FREQ_MHZ;
	localparam int unsigned  CNT_W          = 17;
	localparam logic [CNT_W-1:0] CNT_RESET  = 17'h00000;

	// unlock sequence progress
	typedef enum logic [1:0] {
		DNRW_ULK_IDLE,
		DNRW_ULK_KEY1,
		DNRW_ULK_ARMED
	} dnrw_unlock_t;

	// cell array write engine
	typedef enum logic {
		DNRW_WR_IDLE,
		DNRW_WR_BUSY
	} dnrw_wr_state_t;

endpackage : dnrw_pkg

// File: src/dnrw_top.sv
// data memory read and write controller behind an AHB-Lite register slave
// assumes single word transfers, zero wait states, and a reset-source abort request
// What this block does
// - commit_trigger starts data write, hardware clears it
// - fetch_trigger starts read, hardware clears, set only
// - addressed byte lands in nvm_value next cycle
// - nvm_value holds until next read or write
// - write needs 55h, AAh, then trigger, exactly
// - commit_trigger settable only with unlock enable set
// - hardware never clears commit_unlock_enable
// - clearing enable never disturbs running write
// - completion sets done flag, clears trigger together
// - done flag stays until software clears it
// - program space trigger leaves nvm_value unchanged, no operation
// - reset-cut write sets commit_abort_flag
//
// Decided for this implementation: register access over AHB-Lite and the address map.
module dnrw_top #(
	parameter int unsigned WRITE_CYCLES = dnrw_pkg::WRITE_CYCLES
) (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// reset sources
	input  wire logic        sys_abort_req,
	// interrupt
	output logic             irq
);

	// ---- bus pipeline state ----
	logic                       dp_wr_q;   // a write data phase is in progress
	logic [dnrw_pkg::ADDR_W-1:0] dp_addr_q; // its address
	logic [31:0]                rdata_q;   // read data for the data phase

	// ---- register state ----
	logic                       space_q;   // space_select
	logic                       enable_q;  // commit_unlock_enable
	logic                       abort_q;   // commit_abort_flag
	logic                       commit_q;  // commit_trigger
	logic                       fetch_q;   // fetch_trigger
	logic [7:0]                 index_q;   // nvm_index
	logic [7:0]                 value_q;   // nvm_value
	logic [dnrw_pkg::IRQ_W-1:0] status_q;  // sticky events
	logic [dnrw_pkg::IRQ_W-1:0] mask_q;    // interrupt mask
	dnrw_pkg::dnrw_unlock_t     ulk_q;     // unlock sequence progress
	dnrw_pkg::dnrw_unlock_t     ulk_d;

	// ---- address phase decode ----
	wire logic                       acc_take;   // transfer accepted this edge
	wire logic [dnrw_pkg::ADDR_W-1:0] ap_addr;   // low address bits
	wire logic [31:0]                rd_mux;     // register selected for a read
	wire logic [7:0]                 ctl_view;   // nvm_control as read

	// ---- data phase decode ----
	wire logic [7:0]                 wdata8;     // low write byte
	wire logic                       wr_ctl;
	wire logic                       wr_unlock;
	wire logic                       wr_index;
	wire logic                       wr_value;
	wire logic                       wr_status;
	wire logic                       wr_mask;

	// ---- control events ----
	wire logic                       commit_req;   // software tries to set the trigger
	wire logic                       commit_start; // write really begins
	wire logic                       fetch_go;     // read of data memory
	wire logic                       abort_evt;    // running write cut short
	wire logic [dnrw_pkg::IRQ_W-1:0] irq_set;      // hardware events this cycle
	wire logic [dnrw_pkg::IRQ_W-1:0] irq_clr;      // software write-one-to-clear

	dnrw_mem_if mem_link ();

	// bus answers at once and never errors
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = rdata_q;

	// a transfer is taken when selected, non-idle and the bus is ready
	assign acc_take = hsel & hready & htrans[1];
	assign ap_addr  = haddr[dnrw_pkg::ADDR_W-1:0];

	// control view, unimplemented bits read as zero
	assign ctl_view = {space_q, 3'h0, abort_q, enable_q, commit_q, fetch_q};

	// read selection, unlock port and unmapped offsets read zero
	assign rd_mux =
		(ap_addr == dnrw_pkg::OFF_CONTROL)    ? {24'h000000, ctl_view} :
		(ap_addr == dnrw_pkg::OFF_INDEX)      ? {24'h000000, index_q} :
		(ap_addr == dnrw_pkg::OFF_VALUE)      ? {24'h000000, value_q} :
		(ap_addr == dnrw_pkg::OFF_IRQ_STATUS) ? {30'h0, status_q} :
		(ap_addr == dnrw_pkg::OFF_IRQ_MASK)   ? {30'h0, mask_q} :
		32'h00000000;

	// write strobes in the data phase
	assign wdata8    = hwdata[7:0];
	assign wr_ctl    = dp_wr_q & (dp_addr_q == dnrw_pkg::OFF_CONTROL);
	assign wr_unlock = dp_wr_q & (dp_addr_q == dnrw_pkg::OFF_UNLOCK);
	assign wr_index  = dp_wr_q & (dp_addr_q == dnrw_pkg::OFF_INDEX);
	assign wr_value  = dp_wr_q & (dp_addr_q == dnrw_pkg::OFF_VALUE);
	assign wr_status = dp_wr_q & (dp_addr_q == dnrw_pkg::OFF_IRQ_STATUS);
	assign wr_mask   = dp_wr_q & (dp_addr_q == dnrw_pkg::OFF_IRQ_MASK);

	// a trigger write only counts when the sequence is armed and enabled
	assign commit_req   = wr_ctl & wdata8[dnrw_pkg::CTL_COMMIT_BIT];
	assign commit_start = commit_req
		& (ulk_q == dnrw_pkg::DNRW_ULK_ARMED)
		& enable_q
		& ~wdata8[dnrw_pkg::CTL_SPACE_BIT]
		& ~commit_q;

	// fetch from data space only; program space reads are not served here
	assign fetch_go = wr_ctl & wdata8[dnrw_pkg::CTL_FETCH_BIT]
		& ~wdata8[dnrw_pkg::CTL_SPACE_BIT];

	// reset source while the cells are busy means the byte is lost
	assign abort_evt = sys_abort_req & mem_link.wr_busy;

	// interrupt event and clear vectors
	assign irq_set = {abort_evt, mem_link.wr_done};
	assign irq_clr = wr_status ? wdata8[dnrw_pkg::IRQ_W-1:0] : {dnrw_pkg::IRQ_W{1'b0}};

	// no edge detection: the line stays high until software clears or masks
	// level interrupt while any unmasked event is pending
	assign irq = |(status_q & mask_q);

	// cell array link, write uses the registers loaded beforehand
	assign mem_link.rd_addr  = index_q;
	assign mem_link.wr_start = commit_start;
	assign mem_link.wr_addr  = index_q;  // relies on software loading it first
	assign mem_link.wr_data  = value_q;
	assign mem_link.wr_abort = sys_abort_req;

	// read data is captured at the address phase edge, so a read placed right
	// behind a write to the same register returns the old value; a master that
	// idles between transfers never meets this
	// hsize and the upper address and data bits are not decoded: word access only
	// bus pipeline: note the data phase and prepare read data
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_wr_q   <= 1'b0;
			dp_addr_q <= 8'h00;
			rdata_q   <= 32'h00000000;
		end else if (hready) begin
			dp_wr_q   <= acc_take & hwrite;
			dp_addr_q <= ap_addr;
			if (acc_take && !hwrite) begin
				rdata_q <= rd_mux;
			end
		end
	end

	// a first key in any state restarts at step one, so a repeated first key
	// never locks software out; reads leave the progress alone
	// unlock sequence: any other write in between starts over
	always_comb begin
		ulk_d = ulk_q;
		if (dp_wr_q) begin
			case (ulk_q)
				dnrw_pkg::DNRW_ULK_IDLE: begin
					ulk_d = (wr_unlock && wdata8 == dnrw_pkg::UNLOCK_KEY1) ?
						dnrw_pkg::DNRW_ULK_KEY1 : dnrw_pkg::DNRW_ULK_IDLE;
				end
				dnrw_pkg::DNRW_ULK_KEY1: begin
					if (wr_unlock && wdata8 == dnrw_pkg::UNLOCK_KEY2) begin
						ulk_d = dnrw_pkg::DNRW_ULK_ARMED;
					end else if (wr_unlock && wdata8 == dnrw_pkg::UNLOCK_KEY1) begin
						ulk_d = dnrw_pkg::DNRW_ULK_KEY1;
					end else begin
						ulk_d = dnrw_pkg::DNRW_ULK_IDLE;
					end
				end
				dnrw_pkg::DNRW_ULK_ARMED: begin
					// the next write consumes the arming, whatever it is
					ulk_d = (wr_unlock && wdata8 == dnrw_pkg::UNLOCK_KEY1) ?
						dnrw_pkg::DNRW_ULK_KEY1 : dnrw_pkg::DNRW_ULK_IDLE;
				end
				default: begin
					ulk_d = dnrw_pkg::DNRW_ULK_IDLE;
				end
			endcase
		end
	end

	// unlock state register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ulk_q <= dnrw_pkg::DNRW_ULK_IDLE;
		end else begin
			ulk_q <= ulk_d;
		end
	end

	// plain software fields of the control register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			space_q  <= 1'b0;
			enable_q <= 1'b0;
		end else if (wr_ctl) begin
			space_q  <= wdata8[dnrw_pkg::CTL_SPACE_BIT];
			enable_q <= wdata8[dnrw_pkg::CTL_ENABLE_BIT]; // only software changes it
		end
	end

	// the abort request stands for a reset source about to strike; the flag
	// outlives it because only hresetn itself clears the registers
	// abort flag: hardware set wins over a software write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			abort_q <= 1'b0;
		end else if (abort_evt) begin
			abort_q <= 1'b1;
		end else if (wr_ctl) begin
			abort_q <= wdata8[dnrw_pkg::CTL_ABORT_BIT];
		end
	end

	// timeline: the trigger write edge starts the engine; the cell takes the byte
	// after the write time and the done pulse rises at that same edge; one edge
	// later the trigger drops and the done flag rises together
	// write trigger: held through the whole cycle, writing zero is ignored
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			commit_q <= 1'b0;
		end else if (commit_start) begin
			commit_q <= 1'b1;
		end else if (mem_link.wr_done || abort_evt) begin
			commit_q <= 1'b0; // same edge as the done flag
		end
	end

	// reads back as one only when a read follows the control write at once
	// read trigger: set by software, dropped by hardware one cycle later
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fetch_q <= 1'b0;
		end else begin
			fetch_q <= wr_ctl & wdata8[dnrw_pkg::CTL_FETCH_BIT];
		end
	end

	// a running write copied the index at its start, so it may change now
	// index register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			index_q <= dnrw_pkg::INDEX_RESET;
		end else if (wr_index) begin
			index_q <= wdata8;
		end
	end

	// a fetch aimed at program space leaves the byte alone
	// value register: loaded by a fetch or by software, else held
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			value_q <= dnrw_pkg::VALUE_RESET;
		end else if (fetch_go) begin
			value_q <= mem_link.rd_data; // readable by the very next access
		end else if (wr_value) begin
			value_q <= wdata8;
		end
	end

	// the clear vector comes from the data phase byte, so clearing one event
	// cannot lose another that lands in the same cycle
	// sticky status, an event in the clear cycle survives
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_q <= dnrw_pkg::IRQ_RESET;
		end else begin
			status_q <= (status_q & ~irq_clr) | irq_set; // cleared only by software
		end
	end

	// interrupt mask
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mask_q <= dnrw_pkg::IRQ_RESET;
		end else if (wr_mask) begin
			mask_q <= wdata8[dnrw_pkg::IRQ_W-1:0];
		end
	end

	// cell array with its write timer
	dnrw_cell_array #(
		.WRITE_CYCLES (WRITE_CYCLES)
	) u_cells (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.mem_port (mem_link.mem)
	);

endmodule : dnrw_top

// File: verif/dnrw_ahb_master.sv
// software side model: single-word ahb-lite master issuing register accesses
// assumes one slave whose hreadyout is fed back as hready
module dnrw_ahb_master (
	// clock
	input  wire logic        hclk,
	// request
	output logic             hsel,
	output logic      [31:0] haddr,
	output logic      [1:0]  htrans,
	output logic             hwrite,
	output logic      [2:0]  hsize,
	output logic      [31:0] hwdata,
	// answer
	input  wire logic        hready,
	input  wire logic [31:0] hrdata
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle bus at time zero
	initial begin
		{hsel, haddr, htrans, hwrite, hwdata} = 68'h0;
		hsize = 3'h2;
	end
	// wait for ready at a rising edge, bounded
	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hready !== 1'b1 && n < 16);
		if (hready !== 1'b1) dnrw_top_tb.hang();
	endtask : wait_rdy
	// one word transfer; called right after a rising edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		r = hrdata;
		hwdata <= ~d; // released data no longer shows the old word
	endtask : xfer
endmodule : dnrw_ahb_master

// File: verif/dnrw_top_assertions.sv
// checker for the data memory controller, watching only top-level ports
// assumes a master that idles between transfers and hready tied to hreadyout
module dnrw_top_assertions #(
	parameter int unsigned WRITE_CYCLES = 8
) (
	// clock and reset
	input wire logic        hclk,
	input wire logic        hresetn,
	// bus
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	// events
	input wire logic        sys_abort_req,
	input wire logic        irq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic        wp_q, rp_q, en_q, sp_q, arm_q, enq_q, done_q, chg_q; // bus and shadow state
	logic [7:0]  a_q, lastv_q;                                         // phase address, last byte
	logic [1:0]  k_q, mk_q;                                            // key progress, mask shadow
	logic [31:0] cnt_q;                                                // expected busy cycles left
	wire take   = hsel && hready && htrans[1];
	wire wr_ctl = wp_q && a_q == dnrw_pkg::OFF_CONTROL;
	wire rd_ctl = rp_q && a_q == dnrw_pkg::OFF_CONTROL;
	wire rd_st  = rp_q && a_q == dnrw_pkg::OFF_IRQ_STATUS;
	wire rd_val = rp_q && a_q == dnrw_pkg::OFF_VALUE;
	wire wr_key = wp_q && a_q == dnrw_pkg::OFF_UNLOCK;
	wire start  = wr_ctl && hwdata[1] && !hwdata[7] && en_q && k_q == 2'h2 && cnt_q == 32'h0;
	// shadow of what software did, so reads can be judged
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{wp_q, rp_q, en_q, sp_q, arm_q, enq_q, done_q} <= 7'h00;
			{a_q, lastv_q, k_q, mk_q, cnt_q} <= 52'h0;
			chg_q <= 1'b1;
		end else begin
			wp_q <= take && hwrite;
			rp_q <= take && !hwrite;
			if (take) a_q <= haddr[7:0];
			if (wr_ctl) en_q <= hwdata[2];
			if (wr_ctl && hwdata[1]) {sp_q, arm_q, enq_q} <= {hwdata[7], k_q == 2'h2, en_q};
			if (wp_q && a_q == dnrw_pkg::OFF_IRQ_MASK) mk_q <= hwdata[1:0];
			if (wp_q) k_q <= (wr_key && hwdata[7:0] == 8'h55) ? 2'h1 :
				(wr_key && hwdata[7:0] == 8'hAA && k_q == 2'h1) ? 2'h2 : 2'h0;
			if (start) cnt_q <= WRITE_CYCLES + 1;
			else if (sys_abort_req) cnt_q <= 32'h0;
			else if (cnt_q != 32'h0) cnt_q <= cnt_q - 1;
			if (cnt_q == 32'h1 && !sys_abort_req) done_q <= 1'b1;
			else if (wp_q && a_q == dnrw_pkg::OFF_IRQ_STATUS && hwdata[0]) done_q <= 1'b0;
			if ((wp_q && a_q == dnrw_pkg::OFF_VALUE) || (wr_ctl && hwdata[0] && !hwdata[7]))
				chg_q <= 1'b1;
			else if (rd_val) chg_q <= 1'b0;
			if (rd_val) lastv_q <= hrdata[7:0];
		end
	end
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	// last busy cycle of a write with done unmasked
	sequence s_last;
		cnt_q == 32'h1 && !sys_abort_req && mk_q[0];
	endsequence
	a_commit_reads_one: assert property (
		rd_ctl && $past(cnt_q) != 32'h0 |-> hrdata[1]) else $error("trigger low in write");
	a_refuse_no_enable: assert property (
		rd_ctl && $past(cnt_q) == 32'h0 && !$past(enq_q) |-> !hrdata[1])
		else $error("write began without enable");
	a_refuse_bad_keys: assert property (
		rd_ctl && $past(cnt_q) == 32'h0 && !$past(arm_q) |-> !hrdata[1])
		else $error("write began without keys");
	a_refuse_program_space: assert property (
		rd_ctl && $past(cnt_q) == 32'h0 && $past(sp_q) |-> !hrdata[1])
		else $error("write began in program space");
	a_fetch_self_clears: assert property (
		rd_ctl && !$past(wr_ctl, 2) |-> !hrdata[0]) else $error("fetch bit stuck");
	a_value_holds: assert property (
		rd_val && !$past(chg_q) |-> hrdata[7:0] == lastv_q) else $error("value changed");
	a_enable_kept: assert property (
		rd_ctl |-> hrdata[2] == $past(en_q)) else $error("enable bit changed by hardware");
	a_done_raises_irq: assert property (
		s_last |=> irq) else $error("no done interrupt at write end");
	a_done_sticks: assert property (
		rd_st && $past(done_q) |-> hrdata[0]) else $error("done flag lost");
	a_abort_raises_irq: assert property (
		sys_abort_req && cnt_q > 32'h1 && mk_q[1] |=> irq) else $error("abort not flagged");
	a_disable_keeps_write: assert property (
		rd_ctl && $past(cnt_q) != 32'h0 && !$past(en_q) |-> hrdata[1])
		else $error("clearing enable cut write");
endmodule : dnrw_top_assertions

bind dnrw_top dnrw_top_assertions #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (.hclk(hclk),
	.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hready(hready), .hwdata(hwdata), .hrdata(hrdata), .sys_abort_req(sys_abort_req), .irq(irq));

// File: verif/dnrw_top_tb.sv
// self-checking bench for the data memory controller
// assumes the shortened write cycle below and zero wait states
module dnrw_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned WC  = 8;                      // shortened write time
	localparam logic [7:0]  CTL = dnrw_pkg::OFF_CONTROL;
	localparam logic [7:0]  ULK = dnrw_pkg::OFF_UNLOCK;
	localparam logic [7:0]  IDX = dnrw_pkg::OFF_INDEX;
	localparam logic [7:0]  VAL = dnrw_pkg::OFF_VALUE;
	localparam logic [7:0]  STS = dnrw_pkg::OFF_IRQ_STATUS;
	localparam logic [7:0]  MSK = dnrw_pkg::OFF_IRQ_MASK;
	logic        hclk, hresetn, sys_abort_req, hsel, hwrite, hresp, irq;
	wire         hready;                                  // hreadyout fed back
	logic [31:0] haddr, hwdata, hrdata, rv;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	int          err_count, num_checks;
	always #20 hclk = ~hclk;
	dnrw_top #(.WRITE_CYCLES(WC)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
		.hwdata(hwdata), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
		.sys_abort_req(sys_abort_req), .irq(irq));
	dnrw_ahb_master M (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata));
	// verdict and end of run
	task automatic stop_test();
		if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : stop_test
	// a wait ran out
	task automatic hang();
		err_count++;
		stop_test();
	endtask : hang
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		M.xfer(1'b1, a, d, rv);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		M.xfer(1'b0, a, 32'h0, rv);
	endtask : rd
	// keys back to back, then the control word
	task automatic arm_trig(input logic [7:0] ctl);
		wr(ULK, 32'h55);
		wr(ULK, 32'hAA);
		wr(CTL, {24'h0, ctl});
	endtask : arm_trig
	// poll until the trigger drops, bounded
	task automatic wait_idle();
		int n;
		for (n = 0; n < 30; n++) begin
			rd(CTL);
			if (rv[1] !== 1'b1) break;
		end
		if (n == 30) hang();
	endtask : wait_idle
	// read one byte through the fetch trigger
	task automatic fetch(input logic [7:0] idx, input logic [7:0] exp);
		wr(IDX, {24'h0, idx});
		wr(CTL, 32'h01);
		rd(VAL);
		chk("fetched byte", {24'h0, exp}, rv);
	endtask : fetch
	// every register at zero, unmapped reads zero
	task automatic t_reset();
		logic [7:0] offs[7];
		offs = '{CTL, ULK, IDX, VAL, STS, MSK, 8'h20};
		foreach (offs[i]) begin
			rd(offs[i]);
			chk("reset value", 32'h0, rv);
		end
		chk("reset irq", 32'h0, {31'h0, irq});
		chk("okay response", 32'h0, {31'h0, hresp});
	endtask : t_reset
	// full write, done interrupt, readback
	task automatic t_write();
		wr(MSK, 32'h1);
		wr(IDX, 32'h3C);
		wr(VAL, 32'hA5);
		wr(CTL, 32'h04);
		arm_trig(8'h06);
		rd(CTL);
		chk("trigger busy", 32'h1, {31'h0, rv[1]});
		wr(CTL, 32'h04);
		rd(CTL);
		chk("trigger after zero write", 32'h1, {31'h0, rv[1]});
		wait_idle();
		chk("control after write", 32'h04, rv);
		rd(STS);
		chk("done flag", 32'h1, rv);
		chk("done irq", 32'h1, {31'h0, irq});
		rd(STS);
		chk("done flag kept", 32'h1, rv);
		wr(STS, 32'h1);
		@(posedge hclk);
		chk("irq cleared", 32'h0, {31'h0, irq});
		fetch(8'h3C, 8'hA5);
		rd(CTL);
		chk("fetch bit cleared", 32'h0, rv);
		wr(IDX, 32'h00);
		rd(VAL);
		chk("value held", 32'hA5, rv);
	endtask : t_write
	// refused triggers leave memory alone
	task automatic t_refuse();
		wr(VAL, 32'h11);
		wr(CTL, 32'h00);
		arm_trig(8'h06);
		rd(CTL);
		chk("no enable", 32'h04, rv);
		wr(ULK, 32'h55);
		wr(ULK, 32'h12);
		wr(ULK, 32'hAA);
		wr(CTL, 32'h06);
		rd(CTL);
		chk("broken keys", 32'h04, rv);
		arm_trig(8'h86);
		rd(CTL);
		chk("program space", 32'h84, rv);
		wr(CTL, 32'h04);
		repeat (WC + 4) @(posedge hclk);
		rd(STS);
		chk("no done", 32'h0, rv);
		wr(CTL, 32'h81);
		rd(VAL);
		chk("program space fetch", 32'h11, rv);
		fetch(8'h3C, 8'hA5);
	endtask : t_refuse
	// enable dropped mid-write, then an aborted write
	task automatic t_abort();
		wr(MSK, 32'h3);
		wr(VAL, 32'h5A);
		wr(CTL, 32'h04);
		arm_trig(8'h06);
		wr(CTL, 32'h00);
		wait_idle();
		rd(STS);
		chk("done after enable off", 32'h1, rv);
		wr(STS, 32'h1);
		fetch(8'h3C, 8'h5A);
		wr(VAL, 32'h77);
		wr(CTL, 32'h04);
		arm_trig(8'h06);
		sys_abort_req <= 1'b1;
		@(posedge hclk);
		sys_abort_req <= 1'b0;
		rd(CTL);
		chk("abort control", 32'h0C, rv);
		rd(STS);
		chk("abort status", 32'h2, rv);
		chk("abort irq", 32'h1, {31'h0, irq});
		fetch(8'h3C, 8'h5A);
		wr(STS, 32'h3);
		wr(CTL, 32'h00);
		chk("irq idle", 32'h0, {31'h0, irq});
	endtask : t_abort
	// reset, then the scenarios in order
	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		sys_abort_req = 1'b0;
		err_count = 0;
		num_checks = 0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_write();
		t_refuse();
		t_abort();
		stop_test();
	end
endmodule : dnrw_top_tb
